// ==== rtl/dtc_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

`define DTC_MODE_OFS          8'h00
`define DTC_CTRL_OFS          8'h04
`define DTC_TL0_OFS           8'h08
`define DTC_TH0_OFS           8'h0C
`define DTC_TL1_OFS           8'h10
`define DTC_TH1_OFS           8'h14

`define DTC_MODE_RESET        8'h00
`define DTC_CTRL_RESET        8'h00
`define DTC_COUNT_RESET       8'h00

`define DTC_CTRL_IT0          0
`define DTC_CTRL_IE0          1
`define DTC_CTRL_IT1          2
`define DTC_CTRL_IE1          3
`define DTC_CTRL_TR0          4
`define DTC_CTRL_TF0          5
`define DTC_CTRL_TR1          6
`define DTC_CTRL_TF1          7

`define DTC_MODE0_LSB         0
`define DTC_SRC0_BIT          2
`define DTC_FIRST_GATE_ENABLE_BIT         3
`define DTC_MODE1_LSB         4
`define DTC_SRC1_BIT          6
`define DTC_SECOND_GATE_ENABLE_BIT         7

`define DTC_STATES_PER_CYCLE  12
`define DTC_SAMPLE_STATE      9
`define DTC_UPDATE_STATE      4

`endif

// ==== rtl/dtc_pkg.sv ====
// Types shared by the dual timer/counter
package dtc_pkg;

	typedef logic [7:0]  dtc_byte_t;
	typedef logic [31:0] dtc_word_t;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'b00,
		DTC_MODE_16BIT  = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT  = 2'b11
	} dtc_mode_t;

	typedef enum logic [0:0] {
		DTC_BUS_IDLE = 1'b0,
		DTC_BUS_READ = 1'b1
	} dtc_bus_t;

endpackage

// ==== rtl/dtc_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dtc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1   <= '0;
			pin_sync <= '0;
		end else begin
			stage1   <= pin_in;
			pin_sync <= stage1;
		end
	end

endmodule

// ==== rtl/dtc_tick.sv ====
// Peripheral cycle state divider with sample and update pulses
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_tick #(
	parameter int STATES = `DTC_STATES_PER_CYCLE,
	parameter int SAMPLE = `DTC_SAMPLE_STATE,
	parameter int UPDATE = `DTC_UPDATE_STATE
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// State pulses
	output logic      sample_tick,
	output logic      update_tick
);

	localparam int CW = $clog2(STATES);

	logic [CW-1:0] state_cnt;
	logic          last_state;

	assign last_state = (state_cnt == CW'(STATES - 1));

	// Twelve states per peripheral cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_cnt   <= '0;
			sample_tick <= 1'b0;
			update_tick <= 1'b0;
		end else begin
			state_cnt   <= last_state ? '0 : state_cnt + CW'(1);
			sample_tick <= (state_cnt == CW'(SAMPLE));
			update_tick <= (state_cnt == CW'(UPDATE));
		end
	end

endmodule

// ==== rtl/dtc_top.sv ====
// Dual timer/counter with AHB-Lite register slave
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_top (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire dtc_pkg::dtc_word_t hwdata,
	input  wire logic              hready,
	output dtc_pkg::dtc_word_t     hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Event and gate pins
	input  wire logic              first_event_pin,
	input  wire logic              second_event_pin,
	input  wire logic              first_gate_pin,
	input  wire logic              second_gate_pin,
	// Serial-port clock pulse
	input  wire logic              serial_clock_tick,
	// Interrupt requests and service
	input  wire logic              first_irq_service,
	input  wire logic              second_irq_service,
	output logic                   first_timer_irq,
	output logic                   second_timer_irq
);

	import dtc_pkg::*;

	// Register storage
	dtc_byte_t timer_mode_register;
	dtc_byte_t timer_control_register;
	dtc_byte_t first_count_low_byte;
	dtc_byte_t first_count_high_byte;
	dtc_byte_t second_count_low_byte;
	dtc_byte_t second_count_high_byte;

	// Bus state
	dtc_bus_t  bus_state;
	logic      wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;

	// Pin sampling
	logic [3:0] pins_sync;
	logic       first_sample;
	logic       second_sample;
	logic       first_edge_pend;
	logic       second_edge_pend;
	logic       serial_pend;
	logic       sample_tick;
	logic       update_tick;

	// Sixteen-bit step of one timer: {overflow, high, low}
	function automatic logic [16:0] dtc_step(
		input dtc_mode_t m,
		input dtc_byte_t hi,
		input dtc_byte_t lo
	);
		logic [5:0]  pre;
		logic [16:0] full;
		logic [16:0] res;
		pre  = {1'b0, lo[4:0]} + 6'h01;
		full = {1'b0, hi, lo} + 17'h00001;
		res  = {1'b0, hi, lo};
		case (m)
			DTC_MODE_13BIT: begin
				res[4:0] = pre[4:0];
				if (pre[5]) begin
					res[16:8] = {1'b0, hi} + 9'h001;
				end
			end
			DTC_MODE_16BIT: begin
				res = full;
			end
			DTC_MODE_RELOAD: begin
				if (lo == 8'hFF) begin
					res = {1'b1, hi, hi};
				end else begin
					res[7:0] = lo + 8'h01;
				end
			end
			default: begin
				res = {1'b0, hi, lo};
			end
		endcase
		return res;
	endfunction

	dtc_sync #(
		.WIDTH(4)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  ({second_gate_pin, first_gate_pin,
		           second_event_pin, first_event_pin}),
		.pin_sync(pins_sync)
	);

	dtc_tick #(
		.STATES(`DTC_STATES_PER_CYCLE),
		.SAMPLE(`DTC_SAMPLE_STATE),
		.UPDATE(`DTC_UPDATE_STATE)
	) u_tick (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.sample_tick(sample_tick),
		.update_tick(update_tick)
	);

	// Field decode
	wire dtc_mode_t first_mode;
	wire dtc_mode_t second_mode;
	wire first_count_source_select;
	wire second_count_source_select;
	wire first_gate_enable;
	wire second_gate_enable;
	wire first_timer_run_bit;
	wire second_timer_run_bit;
	wire first_timer_overflow_flag;
	wire second_timer_overflow_flag;

	assign first_mode = dtc_mode_t'(
		timer_mode_register[`DTC_MODE0_LSB +: 2]);
	assign second_mode = dtc_mode_t'(
		timer_mode_register[`DTC_MODE1_LSB +: 2]);
	assign first_count_source_select  = timer_mode_register[`DTC_SRC0_BIT];
	assign second_count_source_select = timer_mode_register[`DTC_SRC1_BIT];
	assign first_gate_enable          = timer_mode_register[`DTC_FIRST_GATE_ENABLE_BIT];
	assign second_gate_enable         = timer_mode_register[`DTC_SECOND_GATE_ENABLE_BIT];
	assign first_timer_run_bit  = timer_control_register[`DTC_CTRL_TR0];
	assign second_timer_run_bit = timer_control_register[`DTC_CTRL_TR1];
	assign first_timer_overflow_flag  =
		timer_control_register[`DTC_CTRL_TF0];
	assign second_timer_overflow_flag =
		timer_control_register[`DTC_CTRL_TF1];

	// Enables and count events
	wire first_split  = (first_mode == DTC_MODE_SPLIT);
	wire second_split = (second_mode == DTC_MODE_SPLIT);
	wire first_enable = first_timer_run_bit &
		(~first_gate_enable | pins_sync[2]);
	wire second_enable = second_timer_run_bit &
		(~second_gate_enable | pins_sync[3]);
	wire first_event = first_count_source_select ?
		first_edge_pend : 1'b1;
	wire second_event = second_count_source_select ?
		second_edge_pend : 1'b1;
	wire first_inc  = update_tick & first_enable & first_event;
	wire second_inc = update_tick & second_enable & second_event &
		~second_split;
	wire first_high_inc = first_split & second_timer_run_bit &
		update_tick & serial_pend;

	wire [16:0] first_step  = dtc_step(first_mode,
		first_count_high_byte, first_count_low_byte);
	wire [16:0] second_step = dtc_step(second_mode,
		second_count_high_byte, second_count_low_byte);

	// Next counts and overflows
	wire dtc_byte_t first_low_inc = first_split ?
		first_count_low_byte + 8'h01 : first_step[7:0];
	wire dtc_byte_t first_high_inc_val = first_split ?
		first_count_high_byte + 8'h01 : first_step[15:8];
	wire first_ovf = first_inc & (first_split ?
		(first_count_low_byte == 8'hFF) : first_step[16]);
	wire first_high_ovf = first_high_inc &
		(first_count_high_byte == 8'hFF);
	wire second_ovf = second_inc & second_step[16];
	wire second_flag_set = first_split ?
		first_high_ovf : second_ovf;
	wire first_high_step = first_split ? first_high_inc : first_inc;

	// Bus decode
	wire bus_take  = hsel & hready & htrans[1];
	wire wr_mode   = wr_pend & (wr_addr == `DTC_MODE_OFS);
	wire wr_ctrl   = wr_pend & (wr_addr == `DTC_CTRL_OFS);
	wire wr_tl0    = wr_pend & (wr_addr == `DTC_TL0_OFS);
	wire wr_th0    = wr_pend & (wr_addr == `DTC_TH0_OFS);
	wire wr_tl1    = wr_pend & (wr_addr == `DTC_TL1_OFS);
	wire wr_th1    = wr_pend & (wr_addr == `DTC_TH1_OFS);
	wire dtc_byte_t wr_byte = hwdata[7:0];
	wire dtc_byte_t rd_byte =
		(rd_addr == `DTC_MODE_OFS) ? timer_mode_register :
		(rd_addr == `DTC_CTRL_OFS) ? timer_control_register :
		(rd_addr == `DTC_TL0_OFS)  ? first_count_low_byte :
		(rd_addr == `DTC_TH0_OFS)  ? first_count_high_byte :
		(rd_addr == `DTC_TL1_OFS)  ? second_count_low_byte :
		(rd_addr == `DTC_TH1_OFS)  ? second_count_high_byte :
		8'h00;

	// Next values; bus write wins over counting, flag set wins over clear
	wire dtc_byte_t next_first_count_low_byte =
		wr_tl0 ? wr_byte :
		first_inc ? first_low_inc : first_count_low_byte;
	wire dtc_byte_t next_first_count_high_byte =
		wr_th0 ? wr_byte :
		first_high_step ? first_high_inc_val : first_count_high_byte;
	wire dtc_byte_t next_second_count_low_byte =
		wr_tl1 ? wr_byte :
		second_inc ? second_step[7:0] : second_count_low_byte;
	wire dtc_byte_t next_second_count_high_byte =
		wr_th1 ? wr_byte :
		second_inc ? second_step[15:8] : second_count_high_byte;
	wire dtc_byte_t ctrl_base = wr_ctrl ? wr_byte : timer_control_register;
	wire next_first_flag = first_ovf |
		(ctrl_base[`DTC_CTRL_TF0] & ~first_irq_service);
	wire next_second_flag = second_flag_set |
		(ctrl_base[`DTC_CTRL_TF1] & ~second_irq_service);
	wire dtc_byte_t next_timer_control_register = {
		next_second_flag, ctrl_base[6],
		next_first_flag, ctrl_base[4:0]};

	// Falling-edge detection on event pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_sample     <= 1'b0;
			second_sample    <= 1'b0;
			first_edge_pend  <= 1'b0;
			second_edge_pend <= 1'b0;
		end else if (sample_tick) begin
			first_sample     <= pins_sync[0];
			second_sample    <= pins_sync[1];
			first_edge_pend  <= first_sample & ~pins_sync[0];
			second_edge_pend <= second_sample & ~pins_sync[1];
		end else if (update_tick) begin
			first_edge_pend  <= 1'b0;
			second_edge_pend <= 1'b0;
		end
	end

	// Serial clock pulses counted once per update state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_pend <= 1'b0;
		end else begin
			serial_pend <= serial_clock_tick |
				(serial_pend & ~update_tick);
		end
	end

	// Timer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_mode_register    <= `DTC_MODE_RESET;
			timer_control_register <= `DTC_CTRL_RESET;
			first_count_low_byte   <= `DTC_COUNT_RESET;
			first_count_high_byte  <= `DTC_COUNT_RESET;
			second_count_low_byte  <= `DTC_COUNT_RESET;
			second_count_high_byte <= `DTC_COUNT_RESET;
		end else begin
			if (wr_mode) begin
				timer_mode_register <= wr_byte;
			end
			timer_control_register <= next_timer_control_register;
			first_count_low_byte   <= next_first_count_low_byte;
			first_count_high_byte  <= next_first_count_high_byte;
			second_count_low_byte  <= next_second_count_low_byte;
			second_count_high_byte <= next_second_count_high_byte;
		end
	end

	// Interrupt outputs follow the flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_timer_irq  <= 1'b0;
			second_timer_irq <= 1'b0;
		end else begin
			first_timer_irq  <= next_first_flag;
			second_timer_irq <= next_second_flag;
		end
	end

	// Bus write capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= bus_take & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// Bus read with one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= DTC_BUS_IDLE;
			rd_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;
			case (bus_state)
				DTC_BUS_IDLE: begin
					if (bus_take & ~hwrite) begin
						bus_state <= DTC_BUS_READ;
						rd_addr   <= haddr[7:0];
						hreadyout <= 1'b0;
					end
				end
				DTC_BUS_READ: begin
					bus_state <= DTC_BUS_IDLE;
					hrdata    <= {24'h000000, rd_byte};
					hreadyout <= 1'b1;
				end
				default: begin
					bus_state <= DTC_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

endmodule

// ==== verification/dtc_pins.sv ====
// Model of the external event and gate pins
`timescale 1ns/1ps
module dtc_pins (
	// Clock
	input  wire logic hclk,
	// Pins
	output logic      first_event_pin,
	output logic      second_event_pin,
	output logic      first_gate_pin,
	output logic      second_gate_pin
);
	logic [1:0] ev = 2'b11;
	logic [1:0] gt = 2'b00;
	assign first_event_pin  = ev[0];
	assign second_event_pin = ev[1];
	assign first_gate_pin   = gt[0];
	assign second_gate_pin  = gt[1];

	// Falling edges, each level held for hold clocks
	task automatic pulse(input logic sel, input int n, input int hold);
		repeat (n) begin
			ev[sel] <= 1'b0;
			repeat (hold) @(posedge hclk);
			ev[sel] <= 1'b1;
			repeat (hold) @(posedge hclk);
		end
	endtask

	task automatic gate(input logic sel, input logic lvl);
		gt[sel] <= lvl;
	endtask
endmodule

// ==== verification/dtc_props.sv ====
// Concurrent checks on the dual timer/counter ports
`timescale 1ns/1ps
module dtc_props (
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Bus handshake
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	// Interrupt requests and service
	input wire logic       first_irq_service,
	input wire logic       second_irq_service,
	input wire logic       first_timer_irq,
	input wire logic       second_timer_irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	wire take_rd = hsel && hready && htrans[1] && !hwrite;
	wire take_wr = hsel && hready && htrans[1] && hwrite;

	property p_rd_wait;
		take_rd |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait state wrong");

	property p_wr_nowait;
		take_wr |=> hreadyout;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait)
		else $error("write not zero wait");

	property p_svc0;
		$rose(first_timer_irq) ##[1:3] first_irq_service |=> !first_timer_irq;
	endproperty
	a_svc0: assert property (p_svc0)
		else $error("first irq kept after service");

	property p_svc1;
		$rose(second_timer_irq) ##[1:3] second_irq_service
			|=> !second_timer_irq;
	endproperty
	a_svc1: assert property (p_svc1)
		else $error("second irq kept after service");

	property p_hold0;
		first_timer_irq && !first_irq_service && !$past(take_wr)
			|=> first_timer_irq;
	endproperty
	a_hold0: assert property (p_hold0)
		else $error("first irq dropped alone");

	property p_hold1;
		second_timer_irq && !second_irq_service && !$past(take_wr)
			|=> second_timer_irq;
	endproperty
	a_hold1: assert property (p_hold1)
		else $error("second irq dropped alone");

	property p_space0;
		$rose(first_timer_irq) |=> (!$rose(first_timer_irq)) [*8];
	endproperty
	a_space0: assert property (p_space0)
		else $error("first irq set twice in a cycle");

	property p_space1;
		$rose(second_timer_irq) |=> (!$rose(second_timer_irq)) [*8];
	endproperty
	a_space1: assert property (p_space1)
		else $error("second irq set twice in a cycle");
endmodule

bind dtc_top dtc_props u_props (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.first_irq_service, .second_irq_service,
	.first_timer_irq, .second_timer_irq
);

// ==== verification/tb_top.sv ====
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`include "dtc_map.svh"
module tb_top;
	import dtc_pkg::*;
	localparam int PC = `DTC_STATES_PER_CYCLE;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	dtc_word_t   hwdata;
	dtc_word_t   hrdata;
	dtc_word_t   rd_q;
	logic        hreadyout;
	logic        hresp;
	logic        serial_clock_tick;
	logic [1:0]  svc;
	wire logic   first_event_pin, second_event_pin;
	wire logic   first_gate_pin, second_gate_pin;
	logic        first_timer_irq, second_timer_irq;
	int          n_fail, checked, n;
	dtc_byte_t   v;

	dtc_top uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.first_event_pin, .second_event_pin, .first_gate_pin,
		.second_gate_pin, .serial_clock_tick,
		.first_irq_service(svc[0]), .second_irq_service(svc[1]),
		.first_timer_irq, .second_timer_irq
	);

	dtc_pins pins (
		.hclk, .first_event_pin, .second_event_pin,
		.first_gate_pin, .second_gate_pin
	);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task automatic chk(input dtc_byte_t seen, input dtc_byte_t exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rdy();
		@(negedge hclk);
		while (hreadyout !== 1'b1) @(negedge hclk);
		rd_q = hrdata;
		@(posedge hclk);
	endtask

	task automatic bus(input logic w, input dtc_byte_t a, input dtc_byte_t d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {24'h000000, a};
		rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		rdy();
	endtask

	task automatic wr(input dtc_byte_t a, input dtc_byte_t d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input dtc_byte_t a, output dtc_byte_t d);
		bus(1'b0, a, 8'h00);
		d = rd_q[7:0];
	endtask

	task automatic wirq(input logic sel, output int k);
		k = 0;
		@(negedge hclk);
		while ((sel ? second_timer_irq : first_timer_irq) !== 1'b1
			&& k < 400) begin
			k++;
			@(negedge hclk);
		end
		@(posedge hclk);
	endtask

	task automatic serve(input logic sel);
		@(posedge hclk);
		svc[sel] <= 1'b1;
		@(posedge hclk);
		svc[sel] <= 1'b0;
		@(posedge hclk);
	endtask

	task automatic tally_and_finish();
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge hclk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		n_fail = 0;
		checked = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		serial_clock_tick = 1'b0;
		svc = 2'b00;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a <= 24; a += 4) begin
			rd(8'(a), v);
			chk(v, 8'h00);
		end
		chk({7'h00, hresp}, 8'h00);
		wr(`DTC_MODE_OFS, 8'hA5);
		rd(`DTC_MODE_OFS, v);
		chk(v, 8'hA5);
		wr(`DTC_CTRL_OFS, 8'h0F);
		rd(`DTC_CTRL_OFS, v);
		chk(v, 8'h0F);
		wr(`DTC_CTRL_OFS, 8'h00);
		wr(`DTC_MODE_OFS, 8'h00);
		// Mode 0: prescaler full, one tick overflows
		wr(`DTC_TL0_OFS, 8'h1F);
		wr(`DTC_TH0_OFS, 8'hFF);
		wr(`DTC_CTRL_OFS, 8'h10);
		wirq(1'b0, n);
		chk(8'(n < PC + 2), 8'h01);
		wr(`DTC_CTRL_OFS, 8'h00);
		rd(`DTC_TH0_OFS, v);
		chk(v, 8'h00);
		// Mode 1: sixteen-bit rollover
		wr(`DTC_MODE_OFS, 8'h01);
		wr(`DTC_TL0_OFS, 8'hFE);
		wr(`DTC_TH0_OFS, 8'hFF);
		wr(`DTC_CTRL_OFS, 8'h10);
		rd(`DTC_TL0_OFS, v);
		chk({1'b0, v[7:1]}, 8'h7F);
		wirq(1'b0, n);
		chk(8'(n <= 2 * PC + 1), 8'h01);
		serve(1'b0);
		rd(`DTC_CTRL_OFS, v);
		chk(v, 8'h10);
		rd(`DTC_TH0_OFS, v);
		chk(v, 8'h00);
		rd(`DTC_TL0_OFS, v);
		chk(8'(v < 8'h08), 8'h01);
		// Mode 2: reload period from high byte
		wr(`DTC_CTRL_OFS, 8'h00);
		wr(`DTC_MODE_OFS, 8'h02);
		wr(`DTC_TH0_OFS, 8'hFE);
		wr(`DTC_TL0_OFS, 8'hFE);
		wr(`DTC_CTRL_OFS, 8'h10);
		wirq(1'b0, n);
		chk(8'(n <= 2 * PC), 8'h01);
		serve(1'b0);
		wirq(1'b0, n);
		chk(8'(n), 8'(2 * PC - 4));
		serve(1'b0);
		rd(`DTC_TH0_OFS, v);
		chk(v, 8'hFE);
		// Gated counting
		wr(`DTC_CTRL_OFS, 8'h00);
		wr(`DTC_MODE_OFS, 8'h09);
		wr(`DTC_TL0_OFS, 8'h00);
		wr(`DTC_CTRL_OFS, 8'h10);
		repeat (5 * PC) @(posedge hclk);
		rd(`DTC_TL0_OFS, v);
		chk(v, 8'h00);
		pins.gate(1'b0, 1'b1);
		repeat (5 * PC) @(posedge hclk);
		wr(`DTC_CTRL_OFS, 8'h00);
		rd(`DTC_TL0_OFS, v);
		chk(8'(v >= 8'h04 && v <= 8'h06), 8'h01);
		pins.gate(1'b0, 1'b0);
		// Event counting at full and slow rate
		wr(`DTC_MODE_OFS, 8'h50);
		wr(`DTC_CTRL_OFS, 8'h40);
		pins.pulse(1'b1, 3, PC);
		pins.pulse(1'b1, 2, 3 * PC);
		rd(`DTC_TL1_OFS, v);
		chk(v, 8'h05);
		wr(`DTC_CTRL_OFS, 8'h00);
		// Split mode: high byte uses second run bit and flag
		wr(`DTC_MODE_OFS, 8'h33);
		wr(`DTC_TH0_OFS, 8'hFF);
		wr(`DTC_TL0_OFS, 8'h00);
		wr(`DTC_CTRL_OFS, 8'h40);
		serial_clock_tick <= 1'b1;
		wirq(1'b1, n);
		chk(8'(n < PC + 2), 8'h01);
		rd(`DTC_CTRL_OFS, v);
		chk(v, 8'hC0);
		rd(`DTC_TL0_OFS, v);
		chk(v, 8'h00);
		serial_clock_tick <= 1'b0;
		wr(`DTC_CTRL_OFS, 8'h00);
		// Second timer halted, then restarted by mode change
		wr(`DTC_MODE_OFS, 8'h33);
		wr(`DTC_CTRL_OFS, 8'h40);
		repeat (3 * PC) @(posedge hclk);
		rd(`DTC_TL1_OFS, v);
		chk(v, 8'h05);
		wr(`DTC_MODE_OFS, 8'h13);
		repeat (3 * PC) @(posedge hclk);
		rd(`DTC_TL1_OFS, v);
		chk(8'(v > 8'h05 && v < 8'h0A), 8'h01);
		tally_and_finish();
	end
endmodule
